// [core/stom_pkg.sv]
/*
 * Shared constants and carrier types of the safe torque off monitor.
 * Assumes a 100 MHz system clock and a plain register port.
 */
package stom_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int EVT_W  = 4;

   // register offsets (byte addresses)
   localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_CODE     = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h10;

   // control fields
   localparam int   CTRL_LATCH_BIT = 0;
   localparam int   CTRL_RESET_BIT = 1;
   localparam logic LATCH_SEL_RST  = 1'b0;

   // status fields
   localparam int ST_GATE_BIT  = 0;
   localparam int ST_MODE_LSB  = 1;
   localparam int ST_ALARM_LSB = 3;
   localparam int ST_CH1_BIT   = 7;
   localparam int ST_CH2_BIT   = 8;
   localparam int ST_REARM_BIT = 9;

   // recorded fault codes
   localparam logic [7:0] CODE_NONE = 8'h00;
   localparam logic [7:0] CODE_CHANNEL_ONE_LOOP_FAULT = 8'h48;
   localparam logic [7:0] CODE_STO  = 8'h4c;
   localparam logic [7:0] CODE_CHANNEL_TWO_LOOP_FAULT = 8'h4d;
   localparam logic [7:0] CODE_INTERNAL_LOOP_FAULT = 8'h4e;

   localparam logic [EVT_W-1:0] IRQ_MASK_RST = 4'h0;

   // timing
   localparam int CLK_HZ       = 100_000_000;
   localparam int STOP_TIME_MS = 20;
   localparam int STOP_CYC     = STOP_TIME_MS * (CLK_HZ / 1000);
   localparam int DISC_TIME_US = 1000;
   localparam int DISC_CYC     = DISC_TIME_US * (CLK_HZ / 1_000_000);
   localparam int DISC_W       = 21;

   typedef enum logic [1:0] {
      STOM_READY,
      STOM_CH1_FAULT,
      STOM_CH2_FAULT,
      STOM_STO
   } stom_mode_e;

   // pin group, high = channel on / internal error present
   typedef struct packed {
      logic intl;
      logic ch2;
      logic ch1;
   } stom_pins_s;

   typedef struct packed {
      logic internal_loop_fault;
      logic channel_two_loop_fault;
      logic channel_one_loop_fault;
      logic sto;
   } stom_evt_s;

endpackage

// [core/stom_sync.sv]
/*
 * Two-flop synchroniser for the safety pin group.
 * Assumes the pins are asynchronous to i_clk.
 */
`timescale 1ns/1ps
module stom_sync
   import stom_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_sys_rst,
   input  wire stom_pins_s i_pins,
   output stom_pins_s      o_pins
);

   typedef struct packed {
      stom_pins_s meta;
      stom_pins_s sync;
   } stom_sync_s;

   stom_sync_s st_ff;
   stom_sync_s nxt_st;

   // first stage feeds only the second
   always_comb
   begin
      nxt_st.meta = i_pins;
      nxt_st.sync = st_ff.meta;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign o_pins = st_ff.sync;

endmodule

// [core/stom_irq.sv]
/*
 * Sticky event status, write-one-to-clear, with mask and level irq.
 * Assumes event inputs are one-cycle pulses on i_clk.
 */
`timescale 1ns/1ps
module stom_irq
   import stom_pkg::*;
(
   input  wire logic             i_clk,
   input  wire logic             i_sys_rst,
   input  wire stom_evt_s        i_evt,
   input  wire logic             i_clr_we,
   input  wire logic             i_mask_we,
   input  wire logic [EVT_W-1:0] i_wdata,
   output logic      [EVT_W-1:0] o_stat,
   output logic      [EVT_W-1:0] o_mask,
   output logic                  o_irq
);

   typedef struct packed {
      logic [EVT_W-1:0] stat;
      logic [EVT_W-1:0] mask;
      logic             irq;
   } stom_irq_s;

   stom_irq_s st_ff;
   stom_irq_s nxt_st;

   always_comb
   begin
      nxt_st = st_ff;
      // a new event beats a clear in the same cycle
      nxt_st.stat = (st_ff.stat & ~(i_clr_we ? i_wdata : '0)) | i_evt;
      if (i_mask_we)
         nxt_st.mask = i_wdata;
      nxt_st.irq = |(nxt_st.stat & nxt_st.mask);
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         st_ff      <= '0;
         st_ff.mask <= IRQ_MASK_RST;
      end
      else
         st_ff <= nxt_st;
   end

   assign o_stat = st_ff.stat;
   assign o_mask = st_ff.mask;
   assign o_irq  = st_ff.irq;

endmodule

// [core/stom_monitor.sv]
/*
 * Safe torque off monitor: classifies the two safety channels, latches
 * alarms, gates the power-stage enable and serves a small register port.
 * Assumes i_run_cmd comes from logic on i_clk; safety pins are async.
 */
`timescale 1ns/1ps
module stom_monitor
   import stom_pkg::*;
#(
   parameter int P_DISC_CYC = DISC_CYC
)
(
   input  wire logic              i_clk,
   input  wire logic              i_sys_rst,
   input  wire logic              i_safety_channel_one_in,
   input  wire logic              i_safety_channel_two_in,
   input  wire logic              i_internal_loop_err,
   input  wire logic              i_run_cmd,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [DATA_W-1:0] o_rdata,
   output logic                   o_gate_enable,
   output stom_mode_e             o_mode,
   output logic      [7:0]        o_fault_code,
   output logic                   o_irq
);

   localparam logic [DISC_W-1:0] DISC_LAST = DISC_W'(P_DISC_CYC - 1);

   typedef struct packed {
      logic              latch_sel;
      logic              sto;
      logic              channel_one_loop_fault;
      logic              channel_two_loop_fault;
      logic              internal_loop_fault;
      logic              rearm;
      logic              gate;
      stom_mode_e        mode;
      logic [7:0]        code;
      logic [DISC_W-1:0] disc;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        warm;
   } stom_mon_s;

   stom_mon_s        st_ff;
   stom_mon_s        nxt_st;
   stom_pins_s       pins_raw;
   stom_pins_s       pins;
   stom_evt_s        evt;
   logic [EVT_W-1:0] irq_stat;
   logic [EVT_W-1:0] irq_mask;
   logic             irq_q;
   logic             reset_cmd;
   logic             both_off;
   logic             one_off;
   logic             live;
   logic             any_fault;
   logic [DATA_W-1:0] status;

   assign pins_raw.ch1  = i_safety_channel_one_in;
   assign pins_raw.ch2  = i_safety_channel_two_in;
   assign pins_raw.intl = i_internal_loop_err;

   stom_sync u_sync
   (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_pins    (pins_raw),
      .o_pins    (pins)
   );

   assign reset_cmd = i_wr && (i_addr == OFS_CTRL) && i_wdata[CTRL_RESET_BIT];
   // sync flops read both channels off until filled after reset; judging
   // them then would latch a false alarm at every power-up
   assign live      = st_ff.warm[1];
   assign both_off  = live && !pins.ch1 && !pins.ch2;
   assign one_off   = live && (pins.ch1 ^ pins.ch2);

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.rdata = '0;
      nxt_st.warm  = {st_ff.warm[0], 1'b1};
      if (i_wr && (i_addr == OFS_CTRL))
         nxt_st.latch_sel = i_wdata[CTRL_LATCH_BIT];

      // a lone drop is given a window for the partner before it is a fault
      if (one_off && st_ff.disc != DISC_LAST)
         nxt_st.disc = st_ff.disc + 1'b1;
      else if (!one_off)
         nxt_st.disc = '0;

      if (one_off && st_ff.disc == DISC_LAST)
      begin
         if (!pins.ch1)
            nxt_st.channel_one_loop_fault = 1'b1;
         else
            nxt_st.channel_two_loop_fault = 1'b1;
      end
      if (pins.intl)
         nxt_st.internal_loop_fault = 1'b1;

      // setting wins over any clearing
      if (both_off)
         nxt_st.sto = 1'b1;
      else if (st_ff.sto && st_ff.latch_sel)
         nxt_st.sto = 1'b0;
      else if (st_ff.sto && reset_cmd)
         nxt_st.sto = 1'b0;

      any_fault = nxt_st.sto || nxt_st.channel_one_loop_fault || nxt_st.channel_two_loop_fault || nxt_st.internal_loop_fault;

      if (any_fault)
         nxt_st.rearm = 1'b1;
      else if (!i_run_cmd)
         nxt_st.rearm = 1'b0;

      // gate drops in the cycle after a synchronised demand
      nxt_st.gate = i_run_cmd && pins.ch1 && pins.ch2 && !any_fault
                    && !nxt_st.rearm;

      if (nxt_st.sto || both_off)
         nxt_st.mode = STOM_STO;
      else if (nxt_st.channel_one_loop_fault || (live && !pins.ch1))
         nxt_st.mode = STOM_CH1_FAULT;
      else if (nxt_st.channel_two_loop_fault || (live && !pins.ch2))
         nxt_st.mode = STOM_CH2_FAULT;
      else
         nxt_st.mode = STOM_READY;

      evt.sto  = nxt_st.sto && !st_ff.sto;
      evt.channel_one_loop_fault = nxt_st.channel_one_loop_fault && !st_ff.channel_one_loop_fault;
      evt.channel_two_loop_fault = nxt_st.channel_two_loop_fault && !st_ff.channel_two_loop_fault;
      evt.internal_loop_fault = nxt_st.internal_loop_fault && !st_ff.internal_loop_fault;

      // most recent fault, internal first when several arrive at once
      if (evt.internal_loop_fault)
         nxt_st.code = CODE_INTERNAL_LOOP_FAULT;
      else if (evt.channel_two_loop_fault)
         nxt_st.code = CODE_CHANNEL_TWO_LOOP_FAULT;
      else if (evt.channel_one_loop_fault)
         nxt_st.code = CODE_CHANNEL_ONE_LOOP_FAULT;
      else if (evt.sto)
         nxt_st.code = CODE_STO;

      status = '0;
      status[ST_GATE_BIT] = st_ff.gate;
      status[ST_MODE_LSB +: 2] = st_ff.mode;
      status[ST_ALARM_LSB +: 4] = {st_ff.internal_loop_fault, st_ff.channel_two_loop_fault, st_ff.channel_one_loop_fault,
                                   st_ff.sto};
      status[ST_CH1_BIT] = pins.ch1;
      status[ST_CH2_BIT] = pins.ch2;
      status[ST_REARM_BIT] = st_ff.rearm;

      if (i_rd)
      begin
         case (i_addr)
            OFS_CTRL:
               nxt_st.rdata = {{(DATA_W-1){1'b0}}, st_ff.latch_sel};
            OFS_STATUS:
               nxt_st.rdata = status;
            OFS_CODE:
               nxt_st.rdata = {{(DATA_W-8){1'b0}}, st_ff.code};
            OFS_IRQ_STAT:
               nxt_st.rdata = {{(DATA_W-EVT_W){1'b0}}, irq_stat};
            OFS_IRQ_MASK:
               nxt_st.rdata = {{(DATA_W-EVT_W){1'b0}}, irq_mask};
            default:
               nxt_st.rdata = '0;
         endcase
      end
   end

   // loop faults have no clear path except the power-on reset
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         st_ff           <= '0;
         st_ff.latch_sel <= LATCH_SEL_RST;
         st_ff.mode      <= STOM_READY;
         st_ff.code      <= CODE_NONE;
      end
      else
         st_ff <= nxt_st;
   end

   stom_irq u_irq
   (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_evt     (evt),
      .i_clr_we  (i_wr && (i_addr == OFS_IRQ_STAT)),
      .i_mask_we (i_wr && (i_addr == OFS_IRQ_MASK)),
      .i_wdata   (i_wdata[EVT_W-1:0]),
      .o_stat    (irq_stat),
      .o_mask    (irq_mask),
      .o_irq     (irq_q)
   );

   assign o_rdata       = st_ff.rdata;
   assign o_gate_enable = st_ff.gate;
   assign o_mode        = st_ff.mode;
   assign o_fault_code  = st_ff.code;
   assign o_irq         = irq_q;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);

   gate_off_demand_a: assert property (
      (!pins.ch1 || !pins.ch2) |=> !o_gate_enable)
      else $error("gate enabled during channel demand");

   gate_follows_run_a: assert property (
      (i_run_cmd && pins.ch1 && pins.ch2 && !st_ff.rearm && !pins.intl
       && !st_ff.sto && !st_ff.channel_one_loop_fault && !st_ff.channel_two_loop_fault && !st_ff.internal_loop_fault
       && one_off == 1'b0) |=> o_gate_enable)
      else $error("gate not following run command");

   sto_entry_a: assert property (
      both_off |=> (st_ff.sto && o_mode == STOM_STO && !o_gate_enable))
      else $error("sto mode not entered");

   channel_one_loop_fault_entry_a: assert property (
      (one_off && !pins.ch1 && st_ff.disc == DISC_LAST) |=> st_ff.channel_one_loop_fault)
      else $error("channel one fault not latched");

   channel_two_loop_fault_entry_a: assert property (
      (one_off && !pins.ch2 && st_ff.disc == DISC_LAST) |=> st_ff.channel_two_loop_fault)
      else $error("channel two fault not latched");

   internal_fault_a: assert property (
      pins.intl |=> (st_ff.internal_loop_fault && !o_gate_enable))
      else $error("internal loop fault not raised");

   stop_time_a: assert property (
      ($fell(i_safety_channel_one_in) || $fell(i_safety_channel_two_in))
      |-> ##[1:4] !o_gate_enable)
      else $error("output not stopped in time");

   sto_latch_a: assert property (
      (st_ff.sto && !st_ff.latch_sel && !reset_cmd) |=> st_ff.sto)
      else $error("latched sto alarm cleared without reset");

   sto_auto_a: assert property (
      (st_ff.sto && st_ff.latch_sel && !both_off) |=> !st_ff.sto)
      else $error("sto alarm did not auto clear");

   loop_sticky_a: assert property (
      (st_ff.channel_one_loop_fault || st_ff.channel_two_loop_fault) |=>
         ((st_ff.channel_one_loop_fault || !$past(st_ff.channel_one_loop_fault))
          && (st_ff.channel_two_loop_fault || !$past(st_ff.channel_two_loop_fault))))
      else $error("loop fault cleared without power cycle");

   code_internal_loop_fault_a: assert property (
      $rose(st_ff.internal_loop_fault) |-> o_fault_code == CODE_INTERNAL_LOOP_FAULT)
      else $error("internal fault code wrong");

   code_channel_one_loop_fault_a: assert property (
      ($rose(st_ff.channel_one_loop_fault) && !$rose(st_ff.internal_loop_fault))
      |-> o_fault_code == CODE_CHANNEL_ONE_LOOP_FAULT)
      else $error("channel one fault code wrong");

   code_sto_a: assert property (
      ($rose(st_ff.sto) && !$rose(st_ff.channel_one_loop_fault) && !$rose(st_ff.channel_two_loop_fault)
       && !$rose(st_ff.internal_loop_fault)) |-> o_fault_code == CODE_STO)
      else $error("safe torque off code wrong");

   startup_quiet_a: assert property (
      !live |=> (!st_ff.sto && !st_ff.channel_one_loop_fault && !st_ff.channel_two_loop_fault))
      else $error("alarm raised before channels were synchronised");

   rearm_hold_a: assert property (
      (st_ff.rearm && i_run_cmd) |=> !o_gate_enable)
      else $error("output resumed without fresh run");

   fault_blocks_a: assert property (
      (st_ff.sto || st_ff.channel_one_loop_fault || st_ff.channel_two_loop_fault || st_ff.internal_loop_fault) |-> !o_gate_enable)
      else $error("gate enabled while a fault stands");

   sto_seen_c: cover property ($rose(st_ff.sto));
   channel_one_loop_fault_seen_c: cover property ($rose(st_ff.channel_one_loop_fault));
   channel_two_loop_fault_seen_c: cover property ($rose(st_ff.channel_two_loop_fault));
   auto_clear_c: cover property (st_ff.latch_sel ##1 $fell(st_ff.sto));
   run_after_c: cover property ($fell(st_ff.rearm) ##[1:20] o_gate_enable);

endmodule

// [test/stom_emergency_stop_switch.sv]
/*
 * Emergency stop switch chain on the two safety channels.
 * Assumes the bench drives i_open and i_lag right after a rising edge.
 */
`timescale 1ns/1ps
module stom_emergency_stop_switch
(
   input  wire logic       i_clk,
   input  wire logic [1:0] i_open,
   input  wire logic [1:0] i_lag,
   output logic            o_ch1,
   output logic            o_ch2
);
   logic [3:0] hist_ff;

   // real contact pairs never move together: lag delays channel two
   always_ff @(posedge i_clk)
   begin
      hist_ff <= {hist_ff[2:0], i_open[1]};
   end

   // an open contact pulls its input to ground, it never floats
   assign o_ch1 = ~i_open[0];
   assign o_ch2 = (i_lag == 2'd0) ? ~i_open[1] : ~hist_ff[i_lag - 2'd1];
endmodule

// [test/safe_torque_off_monitor_tb_top.sv]
/*
 * Self-checking bench of the safe torque off monitor.
 * Assumes stom_pkg and the monitor with its small discrepancy window.
 */
`timescale 1ns/1ps
module safe_torque_off_monitor_tb_top
   import stom_pkg::*;
;
   logic              i_clk;
   logic              i_sys_rst;
   logic              i_internal_loop_err;
   logic              i_run_cmd;
   logic [ADDR_W-1:0] i_addr;
   logic [DATA_W-1:0] i_wdata;
   logic              i_wr;
   logic              i_rd;
   logic [DATA_W-1:0] o_rdata;
   logic              o_gate_enable;
   stom_mode_e        o_mode;
   logic [7:0]        o_fault_code;
   logic              o_irq;
   logic              ch1;
   logic              ch2;
   logic [1:0]        sw_open;
   logic [1:0]        lag;
   logic [31:0]       d;
   logic              prv;
   integer            seed;
   integer            errors;
   integer            tests_run;

   always #5 i_clk = ~i_clk;

   stom_emergency_stop_switch u_stom_emergency_stop_switch (.i_clk(i_clk), .i_open(sw_open), .i_lag(lag),
      .o_ch1(ch1), .o_ch2(ch2));

   stom_monitor #(.P_DISC_CYC(4)) u_stom_monitor (.i_clk(i_clk),
      .i_sys_rst(i_sys_rst), .i_safety_channel_one_in(ch1),
      .i_safety_channel_two_in(ch2), .i_internal_loop_err(i_internal_loop_err),
      .i_run_cmd(i_run_cmd), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .o_gate_enable(o_gate_enable),
      .o_mode(o_mode), .o_fault_code(o_fault_code), .o_irq(o_irq));

   task automatic chk(input string n, input logic [31:0] s,
                      input logic [31:0] e);
      tests_run = tests_run + 1;
      if (s !== e)
      begin
         errors = errors + 1;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= v;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask

   // gate only returns after the run command is released and given anew
   task automatic rerun;
      @(posedge i_clk);
      i_run_cmd <= 1'b0;
      cyc(2);
      i_run_cmd <= 1'b1;
      cyc(3);
      #1;
   endtask

   // channels stay on through reset: the block must come up in standby,
   // with no alarm, code or event left behind
   task automatic pwr;
      @(posedge i_clk);
      i_sys_rst <= 1'b1;
      i_run_cmd <= 1'b0;
      sw_open <= 2'b00;
      lag <= 2'd0;
      i_internal_loop_err <= 1'b0;
      cyc(8);
      i_sys_rst <= 1'b0;
      cyc(6);
      rd(OFS_STATUS);
      chk("alarms", 32'(d[6:3]), 32'h0);
      chk("mode", 32'(o_mode), 32'(STOM_READY));
      rd(OFS_CODE);
      chk("code", d, 32'(CODE_NONE));
      rd(OFS_IRQ_STAT);
      chk("irq_stat", d, 32'h0);
   endtask

   task automatic tally_and_finish;
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      repeat (6000) @(posedge i_clk);
      errors = errors + 1;
      tally_and_finish();
   end

   initial
   begin
      seed = 32'h7752aefa;
      errors = 0;
      tests_run = 0;
      i_clk = 1'b0;
      i_sys_rst = 1'b1;
      i_run_cmd = 1'b0;
      i_internal_loop_err = 1'b0;
      i_addr = 8'h00;
      i_wdata = 32'h0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      sw_open = 2'b00;
      lag = 2'd0;
      prv = 1'b0;
      pwr();
      rd(OFS_CTRL);
      chk("ctrl", d, 32'(LATCH_SEL_RST));
      rd(OFS_IRQ_MASK);
      chk("mask", d, 32'(IRQ_MASK_RST));
      rd(8'h14);
      chk("unmapped", d, 32'h0);
      repeat (40)
      begin
         @(posedge i_clk);
         d = $random(seed);
         i_run_cmd <= d[0];
         #1 chk("gate", 32'(o_gate_enable), 32'(prv));
         prv = i_run_cmd;
      end
      wr(OFS_IRQ_MASK, 32'h1);
      rerun();
      chk("gate", 32'(o_gate_enable), 32'h1);
      @(posedge i_clk);
      sw_open <= 2'b11;
      cyc(4);
      #1 chk("gate", 32'(o_gate_enable), 32'h0);
      chk("mode", 32'(o_mode), 32'(STOM_STO));
      chk("code", 32'(o_fault_code), 32'(CODE_STO));
      cyc(2);
      #1 chk("irq", 32'(o_irq), 32'h1);
      @(posedge i_clk);
      sw_open <= 2'b00;
      cyc(6);
      rd(OFS_STATUS);
      chk("sto", 32'(d[3]), 32'h1);
      chk("gate", 32'(o_gate_enable), 32'h0);
      wr(OFS_CTRL, 32'h2);
      rd(OFS_STATUS);
      chk("sto", 32'(d[3]), 32'h0);
      chk("gate", 32'(o_gate_enable), 32'h0);
      wr(OFS_IRQ_STAT, 32'h1);
      cyc(2);
      #1 chk("irq", 32'(o_irq), 32'h0);
      rerun();
      chk("gate", 32'(o_gate_enable), 32'h1);
      wr(OFS_CTRL, 32'h1);
      @(posedge i_clk);
      lag <= 2'd1;
      sw_open <= 2'b11;
      cyc(6);
      #1 chk("mode", 32'(o_mode), 32'(STOM_STO));
      @(posedge i_clk);
      lag <= 2'd0;
      sw_open <= 2'b00;
      cyc(6);
      rd(OFS_STATUS);
      chk("sto", 32'(d[3]), 32'h0);
      chk("gate", 32'(o_gate_enable), 32'h0);
      rerun();
      chk("gate", 32'(o_gate_enable), 32'h1);
      wr(OFS_CTRL, 32'h0);
      for (int k = 0; k < 3; k++)
      begin
         rerun();
         @(posedge i_clk);
         if (k < 2)
            sw_open <= 2'(k + 1);
         else
            i_internal_loop_err <= 1'b1;
         cyc(4);
         #1 chk("gate", 32'(o_gate_enable), 32'h0);
         if (k < 2)
            chk("mode", 32'(o_mode), k + 1);
         cyc(10);
         sw_open <= 2'b00;
         i_internal_loop_err <= 1'b0;
         cyc(4);
         rd(OFS_CODE);
         chk("code", d, (k == 0) ? 32'(CODE_CHANNEL_ONE_LOOP_FAULT) :
            (k == 1) ? 32'(CODE_CHANNEL_TWO_LOOP_FAULT) : 32'(CODE_INTERNAL_LOOP_FAULT));
         wr(OFS_CTRL, 32'h2);
         rerun();
         rd(OFS_STATUS);
         chk("alarms", 32'(d[6:3]), 32'h2 << k);
         chk("gate", 32'(o_gate_enable), 32'h0);
         pwr();
      end
      tally_and_finish();
   end
endmodule
